/* shared/cxl_pkg.sv */
// Constants and types for the crosspoint latch host controller
package cxl_pkg;
    localparam int CXL_NODE_COUNT = 32;
    localparam int CXL_ADDR_W = 6;
    localparam int CXL_BUS_TOP = 5;
    localparam int CXL_NODE_LSB_X = 3;
    // Phase timing, each phase held for CXL_PHASE_CYC + 1 clocks
    localparam int CXL_PHASE_NS = 30;
    localparam int CXL_CLK_NS = 10;
    localparam logic [3:0] CXL_PHASE_CYC = 4'((CXL_PHASE_NS + CXL_CLK_NS - 1) / CXL_CLK_NS);
    localparam logic [3:0] CXL_CNT_RST = 4'h0;
    // Host command codes
    localparam logic [1:0] CXL_OP_WRITE = 2'h0;
    localparam logic [1:0] CXL_OP_READ = 2'h1;
    localparam logic [1:0] CXL_OP_XFER = 2'h2;
    localparam logic [1:0] CXL_OP_CLEAR = 2'h3;
    typedef enum logic [2:0] {
        CXL_IDLE,
        CXL_SETUP,
        CXL_PULSE,
        CXL_HOLD,
        CXL_DONE
    } cxl_state_t;
endpackage

/* logic/cxl_host.sv */
// Host controller driving the crosspoint two-stage latch pins from a bus-style request port
module cxl_host
    import cxl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Bus-style request port
    input wire logic req_valid,
    input wire logic [CXL_ADDR_W-1:0] req_addr,
    input wire logic req_data,
    input wire logic req_read,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_data,
    // Device pins
    output logic [1:0] x_line_select,
    output logic [2:0] y_line_select,
    output logic chip_select_n,
    output logic read_write,
    output logic stage_one_load_strobe_n,
    output logic stage_two_transfer_strobe_n,
    output logic master_clear_n,
    input wire logic node_value_bit_in,
    output logic node_value_bit_out,
    output logic node_value_bit_oe
);
    cxl_state_t state_q, state_d;
    logic [3:0] cnt_q;
    logic [1:0] op_q;
    logic [CXL_ADDR_W-1:0] addr_q;
    logic data_q;

    // Decode of the six-bit bus address
    wire is_ctrl = req_addr[CXL_BUS_TOP];
    wire [1:0] op_dec = req_read ? CXL_OP_READ :
                        !is_ctrl ? CXL_OP_WRITE :
                        req_addr[0] ? CXL_OP_XFER : CXL_OP_CLEAR;
    wire take = req_valid && req_ready;
    wire cnt_end = (cnt_q == CXL_PHASE_CYC);
    // The command taken at this edge already steers the next pin levels
    wire [1:0] op_cur = take ? op_dec : op_q;
    wire is_write = (op_cur == CXL_OP_WRITE);
    wire is_read = (op_cur == CXL_OP_READ);
    wire is_xfer = (op_cur == CXL_OP_XFER);
    wire is_clear = (op_cur == CXL_OP_CLEAR);
    wire node_op = is_write || is_read;
    wire in_active = (state_d == CXL_SETUP) || (state_d == CXL_PULSE) || (state_d == CXL_HOLD);

    // Active-low strobe level, low only in the pulse phase of its command
    function automatic logic strobe_n(input cxl_state_t st, input logic sel);
        return !((st == CXL_PULSE) && sel);
    endfunction

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            CXL_IDLE: if (take) state_d = CXL_SETUP;
            CXL_SETUP: if (cnt_end) state_d = CXL_PULSE;
            CXL_PULSE: if (cnt_end) state_d = CXL_HOLD;
            CXL_HOLD: if (cnt_end) state_d = CXL_DONE;
            CXL_DONE: state_d = CXL_IDLE;
            default: state_d = CXL_IDLE;
        endcase
    end

    wire phase_move = (state_q != state_d);
    wire [3:0] cnt_d = (phase_move || state_q == CXL_IDLE) ? CXL_CNT_RST : 4'(cnt_q + 4'h1);
    // Pin levels for the next cycle
    wire cs_n_d = !(in_active && node_op);
    wire rw_d = !(in_active && is_write);
    wire load_n_d = strobe_n(state_d, is_write);
    wire xfer_n_d = strobe_n(state_d, is_xfer);
    wire clr_n_d = strobe_n(state_d, is_clear);
    wire oe_d = in_active && is_write;
    wire sample = (state_q == CXL_HOLD) && cnt_end && is_read;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_q <= CXL_IDLE;
            cnt_q <= CXL_CNT_RST;
            op_q <= CXL_OP_WRITE;
            addr_q <= '0;
            data_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (take)
            begin
                op_q <= op_dec;
                addr_q <= req_addr;
                data_q <= req_data;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 1'b0;
            x_line_select <= 2'h0;
            y_line_select <= 3'h0;
            chip_select_n <= 1'b1;
            read_write <= 1'b1;
            stage_one_load_strobe_n <= 1'b1;
            stage_two_transfer_strobe_n <= 1'b1;
            master_clear_n <= 1'b1;
            node_value_bit_out <= 1'b0;
            node_value_bit_oe <= 1'b0;
        end
        else
        begin
            req_ready <= (state_q == CXL_IDLE) && (state_d == CXL_IDLE);
            rsp_valid <= (state_q == CXL_DONE);
            if (sample)
                rsp_data <= node_value_bit_in;
            x_line_select <= take ? req_addr[4:CXL_NODE_LSB_X] : x_line_select;
            y_line_select <= take ? req_addr[CXL_NODE_LSB_X-1:0] : y_line_select;
            chip_select_n <= cs_n_d;
            read_write <= rw_d;
            stage_one_load_strobe_n <= load_n_d;
            stage_two_transfer_strobe_n <= xfer_n_d;
            master_clear_n <= clr_n_d;
            node_value_bit_out <= take ? req_data : node_value_bit_out;
            node_value_bit_oe <= oe_d;
        end
    end

    // Write keeps select and read/write low around the load pulse
    strobe_write_a: assert property (@(posedge sys_clk) disable iff (reset)
        !stage_one_load_strobe_n |-> (!chip_select_n && !read_write && master_clear_n))
        else $error("load strobe outside write cycle");
    load_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(stage_one_load_strobe_n) |-> !stage_one_load_strobe_n [*4] ##1 stage_one_load_strobe_n)
        else $error("load pulse wrong width");
    load_setup_a: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(stage_one_load_strobe_n) |-> !$past(chip_select_n) && $stable(x_line_select) && $stable(y_line_select))
        else $error("address not set up before load");
    load_release_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(stage_one_load_strobe_n) |-> (!chip_select_n && !read_write))
        else $error("select dropped before load strobe rose");
    addr_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        (!chip_select_n && !$past(chip_select_n)) |-> $stable(x_line_select) && $stable(y_line_select))
        else $error("address moved while selected");
    data_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        (node_value_bit_oe && $past(node_value_bit_oe)) |-> $stable(node_value_bit_out))
        else $error("write data moved while driven");
    write_oe_a: assert property (@(posedge sys_clk) disable iff (reset)
        (!chip_select_n && !read_write) |-> node_value_bit_oe)
        else $error("write cycle without data driven");
    data_drive_a: assert property (@(posedge sys_clk) disable iff (reset)
        node_value_bit_oe |-> !read_write)
        else $error("data driven while device may drive");
    read_release_a: assert property (@(posedge sys_clk) disable iff (reset)
        (!chip_select_n && read_write) |-> !node_value_bit_oe)
        else $error("data driven during read cycle");
    read_no_load_a: assert property (@(posedge sys_clk) disable iff (reset)
        read_write |-> stage_one_load_strobe_n)
        else $error("load strobe during read");

    // Transfer and clear each pulse alone for one phase
    xfer_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(stage_two_transfer_strobe_n) |-> !stage_two_transfer_strobe_n [*4] ##1 stage_two_transfer_strobe_n)
        else $error("transfer pulse wrong width");
    xfer_alone_a: assert property (@(posedge sys_clk) disable iff (reset)
        !stage_two_transfer_strobe_n |-> (chip_select_n && stage_one_load_strobe_n && master_clear_n))
        else $error("transfer overlaps other strobes");
    clear_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(master_clear_n) |-> !master_clear_n [*4] ##1 master_clear_n)
        else $error("clear pulse wrong width");
    clear_alone_a: assert property (@(posedge sys_clk) disable iff (reset)
        !master_clear_n |-> (chip_select_n && stage_two_transfer_strobe_n))
        else $error("clear overlaps other strobes");
    oe_no_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
        node_value_bit_oe |-> (master_clear_n && stage_two_transfer_strobe_n))
        else $error("data driven during clear or transfer");

    // Request port handshake and phase counter
    ready_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
        req_ready |-> (chip_select_n && read_write && master_clear_n && stage_two_transfer_strobe_n))
        else $error("ready while pins active");
    take_busy_a: assert property (@(posedge sys_clk) disable iff (reset)
        (req_valid && req_ready) |=> !req_ready)
        else $error("ready stayed high after take");
    rsp_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
        rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    rsp_after_a: assert property (@(posedge sys_clk) disable iff (reset)
        rsp_valid |-> !req_ready)
        else $error("response overlaps ready");
    cnt_bound_a: assert property (@(posedge sys_clk) disable iff (reset)
        cnt_q <= CXL_PHASE_CYC)
        else $error("phase counter out of range");
endmodule // cxl_host

/* test/cxl_dev_model.sv */
// Behavioural model of the crosspoint latch device
module cxl_dev_model (
    // Device pins
    input wire logic [1:0] x_line_select,
    input wire logic [2:0] y_line_select,
    input wire logic chip_select_n,
    input wire logic read_write,
    input wire logic stage_one_load_strobe_n,
    input wire logic stage_two_transfer_strobe_n,
    input wire logic master_clear_n,
    input wire logic node_value_bit_in,
    output logic dev_data,
    output logic dev_oe
);
    timeunit 1ns / 100ps;
    logic [31:0] first_q, second_q;
    wire logic [4:0] node = {x_line_select, y_line_select};
    always_latch
        if (!master_clear_n)
            first_q = 32'h0;
        else if (!chip_select_n && !read_write && !stage_one_load_strobe_n)
            first_q[node] = node_value_bit_in;
    always_latch
        if (!master_clear_n)
            second_q = 32'h0;
        else if (!stage_two_transfer_strobe_n)
            second_q = first_q;
    assign dev_oe = !chip_select_n && read_write && master_clear_n;
    assign dev_data = second_q[node];
endmodule // cxl_dev_model

/* test/crosspoint_two_stage_latch_control_test.sv */
// Self-checking bench for the crosspoint latch host controller
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module crosspoint_two_stage_latch_control_test
    import cxl_pkg::*;
;
    timeunit 1ns / 100ps;
    logic sys_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_data = 1'b0, req_read = 1'b0, float_q = 1'b0;
    logic [CXL_ADDR_W-1:0] req_addr = 6'h00;
    logic req_ready, rsp_valid, rsp_data, chip_select_n, read_write, stage_one_load_strobe_n, master_clear_n;
    logic stage_two_transfer_strobe_n, node_value_bit_out, node_value_bit_oe, dev_data, dev_oe;
    logic [1:0] x_line_select;
    logic [2:0] y_line_select;
    logic [31:0] first_e, second_e;
    int error_cnt = 0, n_compared = 0, cyc = 0;
    wire logic node_value_bit_in = node_value_bit_oe ? node_value_bit_out : (dev_oe ? dev_data : float_q);
    cxl_host cxl_host_i (.*);
    cxl_dev_model cxl_dev_model_i (.*);
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) float_q <= ~float_q;
    always @(posedge sys_clk)
        if (++cyc == 10000)
            complete_run(1);
    task automatic cmd(input logic [5:0] a, input logic d, input logic rd);
        int n = 0;
        while (req_ready !== 1'b1)
            @(posedge sys_clk) #1;
        {req_addr, req_data, req_read, req_valid} = {a, d, rd, 1'b1};
        @(posedge sys_clk) #1;
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 40)
            @(posedge sys_clk) #1 n++;
        `CHK("answer delay", 3 * (int'(CXL_PHASE_CYC) + 1) + 1, n)
    endtask
    task automatic chk_all(input string tname);
        for (int k = 0; k < CXL_NODE_COUNT; k++)
        begin
            cmd({1'b0, 5'(k)}, 1'($urandom), 1'b1);
            `CHK("node state", second_e[k], rsp_data)
        end
        $display("test %s done", tname);
    endtask
    task automatic complete_run(input int hung);
        error_cnt += hung;
        $display("compared %0d mismatched %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        logic [4:0] a;
        void'($urandom(74));
        repeat (5) @(posedge sys_clk);
        #1 reset = 1'b0;
        cmd({1'b1, 4'($urandom), 1'b0}, 1'b0, 1'b0);
        {first_e, second_e} = 64'h0;
        chk_all("clear");
        repeat (40)
        begin
            a = 5'($urandom);
            first_e[a] = 1'($urandom);
            cmd({1'b0, a}, first_e[a], 1'b0);
        end
        chk_all("staged");
        cmd({1'b1, 4'($urandom), 1'b1}, 1'b0, 1'b0);
        second_e = first_e;
        chk_all("transfer");
        cmd({1'b1, 4'($urandom), 1'b0}, 1'b0, 1'b0);
        cmd(6'h21, 1'b0, 1'b0);
        second_e = 32'h0;
        chk_all("clear then transfer");
        complete_run(0);
    end
endmodule // crosspoint_two_stage_latch_control_test
